//--- verilog/shp_consts.vh
// constants for the serial host port pin logic
`ifndef SHP_CONSTS_VH
`define SHP_CONSTS_VH
// mode encodings
`define SHP_MODE_SPI_M 2'h0
`define SHP_MODE_SPI_S 2'h1
`define SHP_MODE_I2C_M 2'h2
`define SHP_MODE_I2C_S 2'h3
// least half-period of generated bit clock, in system clocks
`define SHP_SPI_HALF_MIN 8'h02
`define SHP_I2C_HALF_MIN 8'h03
// word length
`define SHP_WORD_BITS 8
`endif

//--- verilog/shp_pin_logic.v
// serial host port pin logic: spi / i2c master and slave, one word at a time
`timescale 1ns/1ps
`include "shp_consts.vh"
module shp_pin_logic #(
  parameter [7:0] HALF_DIV = 8'h04    // generated clock half-period
) (
  clk_sys,
  rst,
  soft_rst,
  mode,
  cpol,
  cpha,
  tx_data,
  tx_start,
  i2c_gen_start,
  i2c_gen_stop,
  sck_in,
  sck_out,
  sck_oe_n,
  mosi_in,
  mosi_out,
  mosi_oe_n,
  miso_in,
  miso_out,
  miso_oe_n,
  ss_n_in,
  rx_data,
  rx_valid,
  busy,
  bus_error,
  i2c_start_seen,
  i2c_stop_seen
);
  input  wire       clk_sys;        // system clock, 200 MHz
  input  wire       rst;            // asynchronous hardware reset
  input  wire       soft_rst;       // software or individual port reset
  input  wire [1:0] mode;           // spi/i2c, master/slave
  input  wire       cpol;           // clock idle level (spi)
  input  wire       cpha;           // clock phase (spi)
  input  wire [7:0] tx_data;        // word to send
  input  wire       tx_start;       // pulse: begin a master word
  input  wire       i2c_gen_start;  // pulse: master issues start
  input  wire       i2c_gen_stop;   // pulse: master issues stop
  input  wire       sck_in;         // clock pin level (also scl)
  output reg        sck_out;        // clock pin drive value
  output reg        sck_oe_n;       // clock pin enable, low drives
  input  wire       mosi_in;        // mosi pin level
  output reg        mosi_out;       // mosi drive value
  output reg        mosi_oe_n;      // mosi enable, low drives
  input  wire       miso_in;        // miso pin level (also sda)
  output reg        miso_out;       // miso/sda drive value
  output reg        miso_oe_n;      // miso/sda enable, low drives
  input  wire       ss_n_in;        // slave select, active low
  output reg  [7:0] rx_data;        // last received word
  output reg        rx_valid;       // pulse: rx_data updated
  output reg        busy;           // word transfer in progress
  output reg        bus_error;      // sticky, cleared by soft_rst
  output reg        i2c_start_seen; // pulse: start detected
  output reg        i2c_stop_seen;  // pulse: stop detected

  // ==========================================================
  // input synchronisers
  // ==========================================================
  reg [1:0] sck_s_r;                // clock pin synchroniser
  reg [1:0] mosi_s_r;               // mosi synchroniser
  reg [1:0] miso_s_r;               // miso/sda synchroniser
  reg [1:0] ss_s_r;                 // select synchroniser
  reg       sck_d_r;                // last synchronised clock
  reg       sda_d_r;                // last synchronised data

  // only stage two of each synchroniser is read by logic
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_s_r  <= 2'h0;
      mosi_s_r <= 2'h0;
      miso_s_r <= 2'h3;
      ss_s_r   <= 2'h3;
      sck_d_r  <= 1'h0;
      sda_d_r  <= 1'h1;
    end else begin
      sck_s_r  <= {sck_s_r[0], sck_in};
      mosi_s_r <= {mosi_s_r[0], mosi_in};
      miso_s_r <= {miso_s_r[0], miso_in};
      ss_s_r   <= {ss_s_r[0], ss_n_in};
      sck_d_r  <= sck_s_r[1];
      sda_d_r  <= miso_s_r[1];
    end
  end

  wire sck_sy = sck_s_r[1];
  wire sda_sy = miso_s_r[1];
  wire sel    = ~ss_s_r[1];
  wire is_i2c = mode[1];
  wire is_mst = ~mode[0];
  wire sck_rise = sck_sy & ~sck_d_r;
  wire sck_fall = ~sck_sy & sck_d_r;

  // ==========================================================
  // state and registers
  // ==========================================================
  localparam [1:0] ST_IDLE = 2'h0;  // no word moving
  localparam [1:0] ST_LO   = 2'h1;  // master clock low phase
  localparam [1:0] ST_HI   = 2'h2;  // master clock high phase
  localparam [1:0] ST_STOP = 2'h3;  // i2c master stop sequence

  reg [1:0] st_r;                   // master state
  reg [7:0] div_r;                  // half-period counter
  reg [3:0] bit_r;                  // bits left (incl. i2c ack)
  reg [7:0] sh_tx_r;                // transmit shifter
  reg [7:0] sh_rx_r;                // receive shifter
  reg       lead_r;                 // first-half pending (cpha)
  reg       i2c_act_r;              // i2c bus between start and stop
  reg       stop_ph_r;              // stop sequence phase

  // effective half-period, never under the rate limit
  function [7:0] half_of;
    input       i2c;
    input [7:0] req;
    reg   [7:0] lim;
    begin
      lim = i2c ? `SHP_I2C_HALF_MIN : `SHP_SPI_HALF_MIN;
      half_of = (req < lim) ? lim : req;
    end
  endfunction

  wire [7:0] half = half_of(is_i2c, HALF_DIV);
  wire       tick = (div_r == 8'h00);

  // launch / capture edges on the slave side follow cpol^cpha
  wire mode_edge = cpol ^ cpha;
  wire s_cap  = sel & (mode_edge ? sck_fall : sck_rise);
  wire s_lch  = sel & (mode_edge ? sck_rise : sck_fall);
  // i2c conditions: data moves while clock is high
  wire i_start = sck_sy & sck_d_r & sda_d_r & ~sda_sy;
  wire i_stop  = sck_sy & sck_d_r & ~sda_d_r & sda_sy;

  // ==========================================================
  // main process
  // ==========================================================
  // soft_rst behaves like hardware reset for the port pins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      div_r <= 8'h00;
      bit_r <= 4'h0;
      sh_tx_r <= 8'h00;
      sh_rx_r <= 8'h00;
      lead_r <= 1'h0;
      i2c_act_r <= 1'h0;
      stop_ph_r <= 1'h0;
      sck_out <= 1'h0;
      sck_oe_n <= 1'h1;
      mosi_out <= 1'h0;
      mosi_oe_n <= 1'h1;
      miso_out <= 1'h0;
      miso_oe_n <= 1'h1;
      rx_data <= 8'h00;
      rx_valid <= 1'h0;
      busy <= 1'h0;
      bus_error <= 1'h0;
      i2c_start_seen <= 1'h0;
      i2c_stop_seen <= 1'h0;
    end else if (soft_rst) begin
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      i2c_act_r <= 1'h0;
      sck_oe_n <= 1'h1;
      mosi_oe_n <= 1'h1;
      miso_oe_n <= 1'h1;
      rx_valid <= 1'h0;
      busy <= 1'h0;
      bus_error <= 1'h0;
      i2c_start_seen <= 1'h0;
      i2c_stop_seen <= 1'h0;
    end else begin
      rx_valid <= 1'h0;
      i2c_start_seen <= is_i2c & i_start;
      i2c_stop_seen <= is_i2c & i_stop;
      // sticky error; set wins over everything but reset
      if (mode == `SHP_MODE_SPI_M && sel)
        bus_error <= 1'h1;
      div_r <= tick ? half - 8'h01 : div_r - 8'h01;
      case (mode)
        `SHP_MODE_SPI_M: begin
          // clock driven from internal divider
          sck_oe_n <= 1'h0;
          mosi_oe_n <= 1'h0;
          miso_oe_n <= 1'h1;
          case (st_r)
            ST_IDLE: begin
              sck_out <= cpol;
              if (tx_start) begin
                st_r <= ST_LO;
                bit_r <= 4'h8;
                sh_tx_r <= tx_data;
                busy <= 1'h1;
                div_r <= half - 8'h01;
                lead_r <= cpha;
                // cpha=0: first bit must stand before first edge
                if (!cpha)
                  mosi_out <= tx_data[7];
              end
            end
            ST_LO: if (tick) begin
              // leading edge of the clock
              sck_out <= ~cpol;
              st_r <= ST_HI;
              if (lead_r)
                mosi_out <= sh_tx_r[7];
              else
                sh_rx_r <= {sh_rx_r[6:0], miso_s_r[1]};
            end
            ST_HI: if (tick) begin
              // trailing edge of the clock
              sck_out <= cpol;
              if (lead_r)
                sh_rx_r <= {sh_rx_r[6:0], miso_s_r[1]};
              sh_tx_r <= {sh_tx_r[6:0], 1'h0};
              bit_r <= bit_r - 4'h1;
              if (!lead_r)
                mosi_out <= sh_tx_r[6];
              if (bit_r == 4'h1) begin
                st_r <= ST_IDLE;
                busy <= 1'h0;
                rx_valid <= 1'h1;
                rx_data <= lead_r ? {sh_rx_r[6:0], miso_s_r[1]}
                                  : sh_rx_r;
              end else
                st_r <= ST_LO;
            end
            default: st_r <= ST_IDLE;
          endcase
        end
        `SHP_MODE_SPI_S: begin
          sck_oe_n <= 1'h1;
          mosi_oe_n <= 1'h1;
          miso_oe_n <= ~sel;
          st_r <= ST_IDLE;
          if (!sel) begin
            bit_r <= 4'h0;
            busy <= 1'h0;
            sh_tx_r <= tx_data;
            miso_out <= tx_data[7];
          end else begin
            busy <= 1'h1;
            if (s_cap) begin
              sh_rx_r <= {sh_rx_r[6:0], mosi_s_r[1]};
              if (bit_r == 4'h7) begin
                bit_r <= 4'h0;
                rx_valid <= 1'h1;
                rx_data <= {sh_rx_r[6:0], mosi_s_r[1]};
                sh_tx_r <= tx_data;
              end else
                bit_r <= bit_r + 4'h1;
            end
            if (s_lch && !(cpha == 1'h0 && bit_r == 4'h0)) begin
              miso_out <= bit_r == 4'h0 ? sh_tx_r[7]
                        : sh_tx_r[3'h7 - bit_r[2:0]];
            end
          end
        end
        default: begin
          // i2c: both lines open drain, high level from pull-up
          mosi_oe_n <= 1'h1;
          if (i_start) begin
            i2c_act_r <= 1'h1;
            bit_r <= 4'h0;
          end
          if (i_stop)
            i2c_act_r <= 1'h0;
          if (is_mst) begin
            case (st_r)
              ST_IDLE: begin
                sck_oe_n <= 1'h1;
                // start: pull data low while clock high
                if (i2c_gen_start && sck_sy && sda_sy) begin
                  miso_oe_n <= 1'h0;
                  miso_out <= 1'h0;
                end else if (i2c_gen_stop && i2c_act_r) begin
                  st_r <= ST_STOP;
                  stop_ph_r <= 1'h0;
                  div_r <= half - 8'h01;
                end else if (tx_start && i2c_act_r) begin
                  st_r <= ST_LO;
                  bit_r <= 4'h9;             // eight bits and ack
                  sh_tx_r <= tx_data;
                  busy <= 1'h1;
                  div_r <= half - 8'h01;
                  sck_oe_n <= 1'h0;
                  sck_out <= 1'h0;
                end
              end
              ST_LO: if (tick) begin
                // release clock; data was set while low
                sck_oe_n <= 1'h1;
                st_r <= ST_HI;
              end else if (div_r == half - 8'h01) begin
                // drive low for a 0, release for a 1
                miso_out <= 1'h0;
                miso_oe_n <= (bit_r == 4'h1) ? 1'h1 : sh_tx_r[7];
              end
              ST_HI: if (tick && sck_sy) begin
                sck_oe_n <= 1'h0;
                sck_out <= 1'h0;
                if (bit_r > 4'h1)
                  sh_rx_r <= {sh_rx_r[6:0], sda_sy};
                sh_tx_r <= {sh_tx_r[6:0], 1'h1};
                bit_r <= bit_r - 4'h1;
                if (bit_r == 4'h1) begin
                  st_r <= ST_IDLE;
                  busy <= 1'h0;
                  rx_valid <= 1'h1;
                  rx_data <= sh_rx_r;
                  miso_oe_n <= 1'h0;        // hold data low for stop
                end else
                  st_r <= ST_LO;
              end
              default: if (tick) begin
                // stop: clock released, then data released
                if (!stop_ph_r) begin
                  sck_oe_n <= 1'h1;
                  stop_ph_r <= 1'h1;
                end else begin
                  miso_oe_n <= 1'h1;
                  st_r <= ST_IDLE;
                end
              end
            endcase
          end else begin
            // i2c slave: receive only, never holds data low idle
            sck_oe_n <= 1'h1;
            miso_oe_n <= 1'h1;
            st_r <= ST_IDLE;
            busy <= i2c_act_r;
            if (i2c_act_r && sck_rise) begin
              sh_rx_r <= {sh_rx_r[6:0], sda_sy};
              if (bit_r == 4'h7) begin
                rx_valid <= 1'h1;
                rx_data <= {sh_rx_r[6:0], sda_sy};
              end
              bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
            end
          end
        end
      endcase
    end
  end
endmodule

//--- sim/shp_pin_props.sv
// checker: pin behaviour of the serial host port
`timescale 1ns/1ps
`include "shp_consts.vh"
module shp_pin_props #(
  parameter [7:0] HALF_DIV = 8'h04  // generated half-period
) (
  input wire       clk_sys,
  input wire       rst,
  input wire       soft_rst,
  input wire [1:0] mode,
  input wire       ss_n_in,
  input wire       sck_out,
  input wire       sck_oe_n,
  input wire       miso_out,
  input wire       miso_oe_n,
  input wire       busy,
  input wire       tx_start,
  input wire       rx_valid
);
  // ==========================================
  // word time: 16 half-periods, floor of two clocks each
  localparam int HALF = (HALF_DIV < 2) ? 2 : HALF_DIV;
  localparam int W_LO = 16 * HALF - 1;
  localparam int W_HI = 16 * HALF + 2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_pins_in_reset: assert property (disable iff (1'h0)
    (rst || $past(soft_rst)) |-> sck_oe_n && miso_oe_n)
    else $error("port pin driven during reset");
  a_slave_sck_in: assert property (
    mode == `SHP_MODE_SPI_S && $past(mode) == `SHP_MODE_SPI_S |-> sck_oe_n)
    else $error("clock pin driven as spi slave");
  a_miso_off_unsel: assert property (
    (mode == `SHP_MODE_SPI_S && ss_n_in) [*4] |-> miso_oe_n)
    else $error("miso driven while not selected");
  a_sda_low_only: assert property (
    mode[1] && $past(mode[1]) && !miso_oe_n |-> !miso_out)
    else $error("data line driven high in i2c");
  a_scl_low_only: assert property (
    mode == `SHP_MODE_I2C_M && $past(mode) == `SHP_MODE_I2C_M
    && !sck_oe_n |-> !sck_out)
    else $error("i2c clock driven high");
  a_spi_half_min: assert property (
    mode == `SHP_MODE_SPI_M && $changed(sck_out) |=> $stable(sck_out))
    else $error("spi clock half-period under two clocks");
  a_sda_hold_scl: assert property (
    mode == `SHP_MODE_I2C_M && busy && sck_oe_n && $past(sck_oe_n)
    |-> $stable(miso_oe_n))
    else $error("data moved while clock released");
  a_word_time: assert property (
    mode == `SHP_MODE_SPI_M && tx_start && !busy
    |-> ##[W_LO:W_HI] rx_valid)
    else $error("spi word not done in time");
endmodule
bind shp_pin_logic shp_pin_props #(.HALF_DIV(HALF_DIV)) u_props (
  .clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst), .mode(mode),
  .ss_n_in(ss_n_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
  .miso_out(miso_out), .miso_oe_n(miso_oe_n), .busy(busy),
  .tx_start(tx_start), .rx_valid(rx_valid));

//--- sim/shp_far_end.sv
// far-side model: spi slave, pull-ups and external line drivers
`timescale 1ns/1ps
module shp_far_end (
  input  wire       cpol,      // spi clock idle level
  input  wire       slv_en,    // slave model selected, loads reply
  input  wire [7:0] slv_word,  // reply word
  input  wire       ext_sck,   // external clock, 1 releases
  input  wire       ext_mosi,  // external mosi level
  input  wire       ext_sda,   // external data, 1 releases
  input  wire       sck_out,
  input  wire       sck_oe_n,
  input  wire       mosi_out,
  input  wire       mosi_oe_n,
  input  wire       miso_out,
  input  wire       miso_oe_n,
  output wire       sck_pin,
  output wire       mosi_pin,
  output wire       miso_pin,
  output reg  [7:0] got_word
);
  reg [7:0] sh;  // reply shifter, msb on the line
  // ==========================================
  // sck and miso lines: pull-ups, any party may pull low; mosi is muxed
  assign sck_pin  = (sck_oe_n | sck_out) & ext_sck;
  assign mosi_pin = mosi_oe_n ? ext_mosi : mosi_out;
  assign miso_pin = (miso_oe_n | miso_out) & ext_sda & (~slv_en | sh[7]);
  // reply loaded as the slave is selected
  always @(posedge slv_en) sh = slv_word;
  // capture on leading edge, launch on trailing edge
  always @(sck_pin) begin
    if (slv_en && sck_pin !== cpol)
      got_word = {got_word[6:0], mosi_pin};
    else if (slv_en)
      sh = {sh[6:0], ~sh[7]};  // spent bits toggle so stale data shows
  end
endmodule

//--- sim/serial_host_pin_logic_test.sv
// self-checking bench for the serial host port pin logic
`timescale 1ns/1ps
`include "shp_consts.vh"
module serial_host_pin_logic_test;
  reg        clk_sys, rst, soft_rst, cpol, cpha, ss_n_in, slv_en;
  reg  [1:0] mode;
  reg  [2:0] req;  // tx_start, i2c start, i2c stop
  reg  [7:0] tx_data, slv_word;
  reg        ext_sck, ext_mosi, ext_sda;
  reg  [8:0] i2c_got;  // bits seen at i2c clock rises
  wire       sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  wire       sck_pin, mosi_pin, miso_pin, busy, bus_error, rx_valid;
  wire       i2c_start_seen, i2c_stop_seen;
  wire [7:0] rx_data, got_word;
  wire [2:0] ev = {i2c_stop_seen, i2c_start_seen, rx_valid};
  integer    num_errors, compares, n_rx, cyc;
  shp_pin_logic #(.HALF_DIV(8'h04)) uut (
    .clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst), .mode(mode),
    .cpol(cpol), .cpha(cpha), .tx_data(tx_data), .tx_start(req[0]),
    .i2c_gen_start(req[1]), .i2c_gen_stop(req[2]), .sck_in(sck_pin),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_pin),
    .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_pin),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in),
    .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy),
    .bus_error(bus_error), .i2c_start_seen(i2c_start_seen),
    .i2c_stop_seen(i2c_stop_seen));
  shp_far_end far (
    .cpol(cpol), .slv_en(slv_en), .slv_word(slv_word), .ext_sck(ext_sck),
    .ext_mosi(ext_mosi), .ext_sda(ext_sda), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .sck_pin(sck_pin),
    .mosi_pin(mosi_pin), .miso_pin(miso_pin), .got_word(got_word));
  // ==========================================
  // clock, hang guard, event counting
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (rx_valid === 1'h1) n_rx = n_rx + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  always @(posedge sck_pin)
    if (mode == `SHP_MODE_I2C_M) i2c_got = {i2c_got[7:0], miso_pin};
  task check(input string nm, input [8:0] seen, input [8:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  // bounded wait for an event pulse
  task wait_ev(input string nm, input integer k);
    integer n;
    n = 0;
    while (ev[k] !== 1'h1 && n < 3000) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    check(nm, ev[k], 1'h1);
  endtask
  task pulse(input integer k);
    req[k] = 1;
    tick(1);
    req[k] = 0;
  endtask
  task report_and_stop;
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_spi_master(input cp, input [7:0] w, input [7:0] r);
    mode = `SHP_MODE_SPI_M;
    cpol = cp;
    slv_word = r;
    tick(4);
    check("sck_drive", sck_oe_n, 1'h0);
    slv_en = 1;
    tx_data = w;
    pulse(0);
    wait_ev("spi_rx", 0);
    check("spi_rx_data", rx_data, r);
    check("spi_mosi_word", got_word, w);
    check("spi_busy_done", busy, 1'h0);
    slv_en = 0;
    tick(2);
  endtask
  task t_bus_error;
    ss_n_in = 0;
    tick(6);
    check("bus_error", bus_error, 1'h1);
    ss_n_in = 1;
    soft_rst = 1;
    tick(1);
    check("soft_rst_pins", {sck_oe_n, mosi_oe_n, miso_oe_n}, 3'h7);
    soft_rst = 0;
    tick(1);
  endtask
  // link clock at 64 ns, unrelated to the system clock
  task t_spi_slave(input [7:0] w, input [7:0] r);
    integer i, n0;
    reg [7:0] seen;
    mode = `SHP_MODE_SPI_S;
    cpol = 0;
    tx_data = r;
    ext_sck = 0;
    ext_mosi = 1;
    n0 = n_rx;
    tick(4);
    for (i = 0; i < 8; i = i + 1) begin
      #32 ext_sck = 1;
      #32 ext_sck = 0;
    end
    tick(4);
    check("unsel_rx", n_rx - n0, 9'h0);
    check("unsel_miso", miso_oe_n, 1'h1);
    ss_n_in = 0;
    #64;
    for (i = 7; i >= 0; i = i - 1) begin
      ext_mosi = w[i];
      #32 seen = {seen[6:0], miso_pin};
      ext_sck = 1;
      if (i == 0) wait_ev("slave_rx", 0);
      #32 ext_sck = 0;
    end
    check("sel_miso", miso_oe_n, 1'h0);
    check("slave_rx_data", rx_data, w);
    check("slave_tx_bits", seen, r);
    tick(1);
    ss_n_in = 1;
    tick(4);
    check("desel_miso", miso_oe_n, 1'h1);
  endtask
  task t_i2c_master(input [7:0] w);
    mode = `SHP_MODE_I2C_M;
    ext_sck = 1;
    tick(6);
    pulse(1);
    wait_ev("start_gen", 1);
    check("start_sda", miso_pin, 1'h0);
    tx_data = w;
    tick(4);
    pulse(0);
    wait_ev("i2c_done", 0);
    check("i2c_bits", i2c_got, {w, 1'h1});
    pulse(2);
    wait_ev("stop_gen", 2);
    tick(4);
    check("idle_sda", miso_pin, 1'h1);
  endtask
  task t_i2c_slave;
    mode = `SHP_MODE_I2C_S;
    tick(6);
    ext_sda = 0;
    wait_ev("start_det", 1);
    ext_sck = 0;
    tick(4);
    ext_sck = 1;
    tick(4);
    ext_sda = 1;
    wait_ev("stop_det", 2);
    check("slave_lines", {sck_oe_n, miso_oe_n}, 2'h3);
  endtask
  // ==========================================
  // main sequence
  initial begin
    {num_errors, compares, n_rx, cyc} = 0;
    {rst, soft_rst, mode, req, cpol, cpha} = 9'h100;
    {ss_n_in, slv_en, ext_sck, ext_mosi, ext_sda} = 5'h15;
    {tx_data, slv_word} = 16'h0;
    tick(16);
    check("rst_pins", {sck_oe_n, mosi_oe_n, miso_oe_n}, 3'h7);
    rst = 0;
    tick(4);
    t_spi_master(1'h0, 8'hA5, 8'h3C);
    t_spi_master(1'h1, 8'h5A, 8'hC3);
    t_bus_error;
    t_spi_slave(8'h96, 8'h69);
    t_i2c_master(8'hB4);
    t_i2c_slave;
    report_and_stop;
  end
endmodule
